/* slvp_pkg.sv */
package slvp_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses, one 32-bit word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] SLVP_REG_PORT_D   = 8'h00;
	localparam logic [7:0] SLVP_REG_DIR_D    = 8'h04;
	localparam logic [7:0] SLVP_REG_DIR_E    = 8'h08;
	localparam logic [7:0] SLVP_REG_LATCH_E  = 8'h0C;
	localparam logic [7:0] SLVP_REG_PINS_E   = 8'h10;
	localparam logic [7:0] SLVP_REG_CONTROL  = 8'h14;
	localparam logic [7:0] SLVP_REG_CONV_ONE = 8'h18;
	localparam logic [7:0] SLVP_REG_IRQ_STAT = 8'h1C;
	localparam logic [7:0] SLVP_REG_IRQ_CLR  = 8'h20;
	localparam logic [7:0] SLVP_REG_IRQ_EN   = 8'h24;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int SLVP_CTL_IN_FULL  = 7;
	localparam int SLVP_CTL_OUT_FULL = 6;
	localparam int SLVP_CTL_OVERFLOW = 5;
	localparam int SLVP_CTL_ENABLE   = 4;
	localparam int SLVP_EV_WRITE     = 0;
	localparam int SLVP_EV_READ      = 1;
	localparam int SLVP_EV_OVERFLOW  = 2;
	localparam int SLVP_PIN_RD       = 0;
	localparam int SLVP_PIN_WR       = 1;
	localparam int SLVP_PIN_CS       = 2;

	// ----------------------------------------------------------------
	// reset and configuration values
	// ----------------------------------------------------------------
	localparam logic [7:0] SLVP_DIR_RST       = 8'hFF;
	localparam logic [7:0] SLVP_LATCH_RST     = 8'h00;
	localparam logic [2:0] SLVP_CONV_RST      = 3'h0;
	localparam logic [2:0] SLVP_CONV_DIGITAL  = 3'h7;
	localparam logic [7:0] SLVP_STROBE_INPUTS = 8'h07;
	localparam logic [1:0] SLVP_RESP_OKAY     = 2'h0;
	localparam logic [1:0] SLVP_RESP_SLVERR   = 2'h2;

	// ----------------------------------------------------------------
	// state carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       aw_held;
		logic [7:0] awaddr;
		logic       w_held;
		logic [7:0] wdata;
		logic       wlane;
		logic       awready;
		logic       wready;
		logic       bvalid;
		logic [1:0] bresp;
		logic       arready;
		logic       rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} slvp_bus_t;

	typedef struct packed {
		logic [7:0] port_d;
		logic [7:0] dir_d;
		logic [7:0] dir_e;
		logic [7:0] latch_e;
		logic       enable;
		logic       in_full;
		logic       out_full;
		logic       overflow;
		logic [2:0] pin_config;
		logic [2:0] irq_stat;
		logic [2:0] irq_en;
		logic       wr_seen;
		logic       rd_seen;
		logic       internal_mode;
		logic [7:0] pd_out;
		logic [7:0] pd_oe;
		logic [7:0] pe_out;
		logic [7:0] pe_oe;
		logic       irq;
		logic       ttl;
	} slvp_core_t;

endpackage : slvp_pkg

/* slvp_top.sv */
// How it works
// - with the enable bit (bit 4 of the control register) set, port D acts as an 8-bit slave port.
// - the host reads and writes the port with no shared clock, using only its strobes.
// - the port and its control register work only while the internal-only memory mode is in force.
// - the host always moves all eight bits of the port D register in one access.
// - enabling the port makes port E bit 0 the read strobe, bit 1 the write strobe, bit 2 select.
// - port E direction bits 2:0 are held at input while the port is enabled.
// - the strobes act only once the analog pin configuration makes port E 2:0 digital.
// - a write happens at the first cycle select and write strobe are both seen low.
// - a read happens at the first cycle select and read strobe are both seen low.
// - while read strobe and select are low the port D register is driven onto the bus.
// - the port D register is loaded from the bus only at the first cycle write strobe and select are seen low.
// - with select high both strobes are ignored.
// - while the port is enabled the control inputs use TTL thresholds.
`timescale 1ns/1ps
`default_nettype none

module slvp_top
	import slvp_pkg::*;
(
	input  wire logic        ref_clk,        // system clock, 200 MHz
	input  wire logic        reset_n,        // synchronous reset, active low
	input  wire logic [7:0]  s_axi_awaddr,   // write address
	input  wire logic        s_axi_awvalid,  // write address valid
	output logic             s_axi_awready,  // write address ready
	input  wire logic [31:0] s_axi_wdata,    // write data
	input  wire logic [3:0]  s_axi_wstrb,    // write byte strobes
	input  wire logic        s_axi_wvalid,   // write data valid
	output logic             s_axi_wready,   // write data ready
	output logic [1:0]       s_axi_bresp,    // write response
	output logic             s_axi_bvalid,   // write response valid
	input  wire logic        s_axi_bready,   // write response ready
	input  wire logic [7:0]  s_axi_araddr,   // read address
	input  wire logic        s_axi_arvalid,  // read address valid
	output logic             s_axi_arready,  // read address ready
	output logic [31:0]      s_axi_rdata,    // read data
	output logic [1:0]       s_axi_rresp,    // read response
	output logic             s_axi_rvalid,   // read data valid
	input  wire logic        s_axi_rready,   // read data ready
	input  wire logic        internal_mode,  // program memory in internal-only mode
	input  wire logic [7:0]  port_d_in,      // port D pin levels
	output logic [7:0]       port_d_out,     // port D drive value
	output logic [7:0]       port_d_oe,      // port D output enables
	input  wire logic [7:0]  port_e_in,      // port E pin levels
	output logic [7:0]       port_e_out,     // port E drive value
	output logic [7:0]       port_e_oe,      // port E output enables
	output logic             ttl_select,     // port E control inputs on TTL thresholds
	output logic             irq             // level interrupt
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------

	// true for an address that hits a register
	function automatic logic slvp_mapped(input logic [7:0] addr);
		unique case (addr)
			SLVP_REG_PORT_D, SLVP_REG_DIR_D, SLVP_REG_DIR_E, SLVP_REG_LATCH_E,
			SLVP_REG_PINS_E, SLVP_REG_CONTROL, SLVP_REG_CONV_ONE,
			SLVP_REG_IRQ_STAT, SLVP_REG_IRQ_CLR, SLVP_REG_IRQ_EN: slvp_mapped = 1'b1;
			default: slvp_mapped = 1'b0;
		endcase
	endfunction : slvp_mapped

	slvp_bus_t  bus_r;
	slvp_bus_t  bus_nxt;
	slvp_core_t core_r;
	slvp_core_t core_nxt;

	logic        sw_write;    // register write carried out this cycle
	logic        sw_read;     // register read accepted this cycle
	logic        port_active; // slave port fully enabled
	logic        cs_low;
	logic        wr_now;
	logic        rd_now;
	logic        wr_first;
	logic        rd_first;
	logic [31:0] read_word;

	// ----------------------------------------------------------------
	// bus events and port decode
	// ----------------------------------------------------------------

	// a write goes ahead once address and data are both held
	assign sw_write = bus_r.aw_held && bus_r.w_held && !bus_r.bvalid;
	assign sw_read  = s_axi_arvalid && bus_r.arready;

	// port active only in internal mode with digital control pins
	assign port_active = core_r.enable && core_r.internal_mode
		&& (core_r.pin_config == SLVP_CONV_DIGITAL);
	assign cs_low   = port_active && !port_e_in[SLVP_PIN_CS];
	assign wr_now   = cs_low && !port_e_in[SLVP_PIN_WR];
	assign rd_now   = cs_low && !port_e_in[SLVP_PIN_RD];
	assign wr_first = wr_now && !core_r.wr_seen;
	assign rd_first = rd_now && !core_r.rd_seen;

	// register read mux
	always_comb begin
		read_word = 32'h0000_0000;
		unique case (s_axi_araddr)
			SLVP_REG_PORT_D:   read_word[7:0] = core_r.enable ? core_r.port_d : port_d_in;
			SLVP_REG_DIR_D:    read_word[7:0] = core_r.dir_d;
			SLVP_REG_DIR_E:    read_word[7:0] = core_r.dir_e;
			SLVP_REG_LATCH_E:  read_word[7:0] = core_r.latch_e;
			SLVP_REG_PINS_E:   read_word[7:0] = port_e_in;
			SLVP_REG_CONTROL: begin
				read_word[SLVP_CTL_IN_FULL]  = core_r.in_full;
				read_word[SLVP_CTL_OUT_FULL] = core_r.out_full;
				read_word[SLVP_CTL_OVERFLOW] = core_r.overflow;
				read_word[SLVP_CTL_ENABLE]   = core_r.enable;
			end
			SLVP_REG_CONV_ONE: read_word[2:0] = core_r.pin_config;
			SLVP_REG_IRQ_STAT: read_word[2:0] = core_r.irq_stat;
			SLVP_REG_IRQ_EN:   read_word[2:0] = core_r.irq_en;
			default:           read_word = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------

	// next state of the bus handshakes
	always_comb begin
		bus_nxt = bus_r;
		if (s_axi_awvalid && bus_r.awready) begin
			bus_nxt.aw_held = 1'b1;
			bus_nxt.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && bus_r.wready) begin
			bus_nxt.w_held = 1'b1;
			bus_nxt.wdata  = s_axi_wdata[7:0];
			bus_nxt.wlane  = s_axi_wstrb[0];
		end
		if (sw_write) begin
			bus_nxt.aw_held = 1'b0;
			bus_nxt.w_held  = 1'b0;
			bus_nxt.bvalid  = 1'b1;
			bus_nxt.bresp   = slvp_mapped(bus_r.awaddr) ? SLVP_RESP_OKAY : SLVP_RESP_SLVERR;
		end else if (bus_r.bvalid && s_axi_bready) begin
			bus_nxt.bvalid = 1'b0;
		end
		bus_nxt.awready = !bus_nxt.aw_held && !bus_nxt.bvalid;
		bus_nxt.wready  = !bus_nxt.w_held && !bus_nxt.bvalid;
		if (sw_read) begin
			bus_nxt.rvalid = 1'b1;
			bus_nxt.rdata  = read_word;
			bus_nxt.rresp  = slvp_mapped(s_axi_araddr) ? SLVP_RESP_OKAY : SLVP_RESP_SLVERR;
		end else if (bus_r.rvalid && s_axi_rready) begin
			bus_nxt.rvalid = 1'b0;
		end
		bus_nxt.arready = !bus_nxt.rvalid;
	end

	// bus state registers
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			bus_r <= '0;
		end else begin
			bus_r <= bus_nxt;
		end
	end

	assign s_axi_awready = bus_r.awready;
	assign s_axi_wready  = bus_r.wready;
	assign s_axi_bvalid  = bus_r.bvalid;
	assign s_axi_bresp   = bus_r.bresp;
	assign s_axi_arready = bus_r.arready;
	assign s_axi_rvalid  = bus_r.rvalid;
	assign s_axi_rdata   = bus_r.rdata;
	assign s_axi_rresp   = bus_r.rresp;

	// ----------------------------------------------------------------
	// port core
	// ----------------------------------------------------------------

	// next state of registers, flags and pins
	always_comb begin
		logic       lane;
		logic [2:0] events;
		lane     = sw_write && bus_r.wlane;
		events   = 3'h0;
		core_nxt = core_r;
		core_nxt.internal_mode = internal_mode;
		core_nxt.wr_seen = wr_now;
		core_nxt.rd_seen = rd_now;

		// software side: writes and read side effects
		if (lane) begin
			unique case (bus_r.awaddr)
				SLVP_REG_PORT_D: begin
					core_nxt.port_d = bus_r.wdata;
					if (port_active)
						core_nxt.out_full = 1'b1;
				end
				SLVP_REG_DIR_D:    core_nxt.dir_d = bus_r.wdata;
				SLVP_REG_DIR_E: begin
					core_nxt.dir_e = bus_r.wdata;
					if (core_r.enable)
						core_nxt.dir_e[2:0] = core_r.dir_e[2:0];
				end
				SLVP_REG_LATCH_E:  core_nxt.latch_e = bus_r.wdata;
				SLVP_REG_CONTROL: begin
					if (core_r.internal_mode) begin
						core_nxt.enable = bus_r.wdata[SLVP_CTL_ENABLE];
						if (!bus_r.wdata[SLVP_CTL_OVERFLOW])
							core_nxt.overflow = 1'b0;
					end
				end
				SLVP_REG_CONV_ONE: core_nxt.pin_config = bus_r.wdata[2:0];
				SLVP_REG_IRQ_CLR:  core_nxt.irq_stat = core_r.irq_stat & ~bus_r.wdata[2:0];
				SLVP_REG_IRQ_EN:   core_nxt.irq_en = bus_r.wdata[2:0];
				default: ;
			endcase
		end
		if (sw_read && s_axi_araddr == SLVP_REG_PORT_D)
			core_nxt.in_full = 1'b0;

		// host write: whole byte taken on first detection, flags set over clears
		if (wr_first) begin
			core_nxt.port_d = port_d_in;
			core_nxt.in_full = 1'b1;
			events[SLVP_EV_WRITE] = 1'b1;
			if (core_r.in_full) begin
				core_nxt.overflow = 1'b1;
				events[SLVP_EV_OVERFLOW] = 1'b1;
			end
		end
		// host read clears output-full on first detection
		if (rd_first) begin
			core_nxt.out_full = 1'b0;
			events[SLVP_EV_READ] = 1'b1;
		end
		core_nxt.irq_stat = core_nxt.irq_stat | events;

		// leaving the internal-only mode drops the port
		if (!core_r.internal_mode)
			core_nxt.enable = 1'b0;
		if (core_nxt.enable)
			core_nxt.dir_e[2:0] = SLVP_STROBE_INPUTS[2:0];

		// port D drives the register only during a host read when enabled
		core_nxt.pd_out = core_nxt.port_d;
		if (core_nxt.enable)
			core_nxt.pd_oe = rd_now ? 8'hFF : 8'h00;
		else
			core_nxt.pd_oe = ~core_nxt.dir_d;
		core_nxt.pe_out = core_nxt.latch_e;
		core_nxt.pe_oe  = ~core_nxt.dir_e;
		core_nxt.ttl    = core_nxt.enable;
		core_nxt.irq    = |(core_nxt.irq_stat & core_nxt.irq_en);
	end

	// core state registers
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			core_r            <= '0;
			core_r.port_d     <= SLVP_LATCH_RST;
			core_r.dir_d      <= SLVP_DIR_RST;
			core_r.dir_e      <= SLVP_DIR_RST;
			core_r.latch_e    <= SLVP_LATCH_RST;
			core_r.pin_config <= SLVP_CONV_RST;
		end else begin
			core_r <= core_nxt;
		end
	end

	assign port_d_out = core_r.pd_out;
	assign port_d_oe  = core_r.pd_oe;
	assign port_e_out = core_r.pe_out;
	assign port_e_oe  = core_r.pe_oe;
	assign ttl_select = core_r.ttl;
	assign irq        = core_r.irq;

endmodule : slvp_top

`default_nettype wire

/* slvp_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module slvp_props
	import slvp_pkg::*;
(
	input wire logic       ref_clk,       // clock
	input wire logic       reset_n,       // reset
	input wire logic       s_axi_awvalid, // aw valid
	input wire logic       s_axi_awready, // aw ready
	input wire logic       s_axi_bvalid,  // b valid
	input wire logic       s_axi_arvalid, // ar valid
	input wire logic       s_axi_arready, // ar ready
	input wire logic       s_axi_rvalid,  // r valid
	input wire logic       internal_mode, // memory mode
	input wire logic [7:0] port_d_in,     // d pins
	input wire logic [7:0] port_d_out,    // d drive
	input wire logic [7:0] port_d_oe,     // d enables
	input wire logic [7:0] port_e_in,     // e pins
	input wire logic [7:0] port_e_oe,     // e enables
	input wire logic       ttl_select     // ttl mode
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	logic cs;
	logic rd;
	logic wr;
	logic on;
	// decoded strobes and port activity
	assign cs = port_e_in[SLVP_PIN_CS];
	assign rd = port_e_in[SLVP_PIN_RD];
	assign wr = port_e_in[SLVP_PIN_WR];
	assign on = ttl_select && internal_mode;
	// first edge of a host write, and a held host read
	sequence s_wr_first;
		on && $past(internal_mode) && !cs && !wr && $past(cs || wr);
	endsequence
	sequence s_rd_held;
		on && $past(internal_mode) && !cs && !rd ##1 on && !cs && !rd;
	endsequence
	a_write_capture: assert property (s_wr_first |=> port_d_out == $past(port_d_in))
		else $error("host write not captured");
	a_read_drive: assert property (s_rd_held |-> port_d_oe == 8'hFF)
		else $error("host read not driven");
	a_drive_cause: assert property (ttl_select && port_d_oe == 8'hFF |-> $past(!cs && !rd))
		else $error("bus driven without read");
	a_dir_e_held: assert property (ttl_select && $past(ttl_select) |-> port_e_oe[2:0] == 3'h0)
		else $error("strobe pins driven");
	a_out_cause: assert property ($past(ttl_select) && port_d_out != $past(port_d_out)
		&& !s_axi_bvalid && !$past(s_axi_bvalid) |-> $past(!cs && !wr))
		else $error("port d changed without write");
	a_mode_gate: assert property (!internal_mode [*3] |-> !ttl_select)
		else $error("port active outside mode");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
		else $error("write not answered");
endmodule : slvp_props

bind slvp_top slvp_props u_props (.ref_clk, .reset_n, .s_axi_awvalid, .s_axi_awready,
	.s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .internal_mode, .port_d_in,
	.port_d_out, .port_d_oe, .port_e_in, .port_e_oe, .ttl_select);
`default_nettype wire

/* slvp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// external host model
// ----------------------------------------
module slvp_host_model (
	input  wire logic       ref_clk,    // clock
	input  wire logic [7:0] port_d_out, // device drive
	input  wire logic [7:0] port_d_oe,  // device enables
	output logic      [7:0] port_d_in,  // bus level
	output logic      [7:0] port_e_in   // strobes
);
	logic [7:0] hd_r; // host data
	logic [2:0] st_r; // select, write, read
	// bus level: device where it drives, host elsewhere
	assign port_d_in = (port_d_oe & port_d_out) | (~port_d_oe & hd_r);
	assign port_e_in = {5'h00, st_r};
	initial begin
		hd_r = 8'h00;
		st_r = 3'h7;
	end
	// whole byte, strobes held three edges, then released for one
	task hwrite(input logic [7:0] d, input logic sel);
		@(posedge ref_clk);
		hd_r <= d;
		st_r <= {sel, 1'b0, 1'b1};
		repeat (3) @(posedge ref_clk);
		st_r <= 3'h7;
		@(posedge ref_clk);
		hd_r <= ~d; // released bus shows the inverse
	endtask : hwrite
	// read: sample the bus while select and read are low
	task hread(output logic [7:0] d);
		@(posedge ref_clk);
		st_r <= 3'b010;
		repeat (3) @(posedge ref_clk);
		d = port_d_in;
		st_r <= 3'h7;
		@(posedge ref_clk);
	endtask : hread
endmodule : slvp_host_model
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// bench top
// ----------------------------------------
module testbench;
	import slvp_pkg::*;
	`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
		$display("ERROR %s exp %h got %h", nm, e, g); end end
	logic        ref_clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, internal_mode, ttl_select, irq;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, port_d_in, port_d_out, port_d_oe;
	logic [7:0]  port_e_in, port_e_out, port_e_oe, hv;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	int          n_mismatch, num_checks;
	// clock
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	slvp_top uut (.ref_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .internal_mode, .port_d_in, .port_d_out,
		.port_d_oe, .port_e_in, .port_e_out, .port_e_oe, .ttl_select, .irq);
	slvp_host_model uhost (.ref_clk, .port_d_out, .port_d_oe, .port_d_in, .port_e_in);
	// verdict
	task wrap_up;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	// bus write: address and data offered together, bready held until bvalid
	task axw(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge ref_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n == 100) begin
			n_mismatch++;
			wrap_up();
		end
	endtask : axw
	// bus read: rready held until rvalid
	task axr(input logic [7:0] a);
		int n;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge ref_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		rd_v = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n == 100) begin
			n_mismatch++;
			wrap_up();
		end
	endtask : axr
	// read a register and compare word and response
	task rchk(input logic [7:0] a, input logic [31:0] e);
		axr(a);
		`CHK($sformatf("resp %h", a), SLVP_RESP_OKAY, rsp)
		`CHK($sformatf("reg %h", a), e, rd_v)
	endtask : rchk
	// main sequence
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
		internal_mode = 1'b1;
		reset_n = 1'b0;
		n_mismatch = 0;
		num_checks = 0;
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		rchk(SLVP_REG_CONTROL, 32'h00);
		rchk(SLVP_REG_DIR_E, 32'hFF);
		rchk(SLVP_REG_CONV_ONE, 32'h00);
		axr(8'h3C);
		`CHK("unmapped read", SLVP_RESP_SLVERR, rsp)
		axw(8'h3C, 32'h1);
		`CHK("unmapped write", SLVP_RESP_SLVERR, rsp)
		$display("test reset done");
		axw(SLVP_REG_CONV_ONE, 32'h7);
		axw(SLVP_REG_CONTROL, 32'h10);
		axw(SLVP_REG_DIR_E, 32'h00);
		axw(SLVP_REG_IRQ_EN, 32'h7);
		rchk(SLVP_REG_CONTROL, 32'h10);
		rchk(SLVP_REG_DIR_E, 32'h07);
		`CHK("ttl", 1'b1, ttl_select)
		`CHK("e oe", 8'hF8, port_e_oe)
		axw(SLVP_REG_LATCH_E, 32'h5C);
		`CHK("e out", 8'h5C, port_e_out)
		rchk(SLVP_REG_PINS_E, 32'h07);
		$display("test enable done");
		uhost.hwrite(8'h5A, 1'b0);
		rchk(SLVP_REG_CONTROL, 32'h90);
		rchk(SLVP_REG_IRQ_STAT, 32'h1);
		`CHK("irq", 1'b1, irq)
		uhost.hwrite(8'hA5, 1'b0);
		rchk(SLVP_REG_CONTROL, 32'hB0);
		rchk(SLVP_REG_IRQ_STAT, 32'h5);
		uhost.hwrite(8'h66, 1'b1);
		`CHK("d out", 8'hA5, port_d_out)
		rchk(SLVP_REG_PORT_D, 32'hA5);
		$display("test host write done");
		axw(SLVP_REG_PORT_D, 32'h3C);
		rchk(SLVP_REG_CONTROL, 32'h70);
		uhost.hread(hv);
		`CHK("host read", 8'h3C, hv)
		rchk(SLVP_REG_CONTROL, 32'h30);
		`CHK("d oe idle", 8'h00, port_d_oe)
		rchk(SLVP_REG_IRQ_STAT, 32'h7);
		$display("test host read done");
		axw(SLVP_REG_CONTROL, 32'h10);
		axw(SLVP_REG_IRQ_CLR, 32'h7);
		rchk(SLVP_REG_IRQ_STAT, 32'h0);
		`CHK("irq clr", 1'b0, irq)
		axw(SLVP_REG_IRQ_EN, 32'h0);
		uhost.hwrite(8'h11, 1'b0);
		`CHK("irq mask", 1'b0, irq)
		rchk(SLVP_REG_PORT_D, 32'h11);
		rchk(SLVP_REG_CONTROL, 32'h10);
		axw(SLVP_REG_IRQ_CLR, 32'h7);
		$display("test irq done");
		internal_mode <= 1'b0;
		repeat (4) @(posedge ref_clk);
		`CHK("ttl off", 1'b0, ttl_select)
		uhost.hwrite(8'h22, 1'b0);
		rchk(SLVP_REG_IRQ_STAT, 32'h0);
		axw(SLVP_REG_CONTROL, 32'h10);
		rchk(SLVP_REG_CONTROL, 32'h00);
		$display("test mode done");
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
